//--- edp_pointers.sv
/*
 * Transmit and receive descriptor start pointers with register port,
 * completion write-back and a small status register.
 * Assumes the DMA engines and register master run on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// RULE1: The transmit pointer keeps address bits 31..2 of the first transmit descriptor.
// RULE2: The receive pointer keeps address bits 31..2 of the first receive descriptor.
// RULE3: Start addresses are word aligned; bits 1..0 are not stored and read as zero.
// RULE4: Software should not write a pointer while transmit, receive or DMA is active.
// RULE5: A successful packet overwrites its pointer with the last descriptor used.
// RULE6: Only the transmit engine sees and updates the transmit pointer.
// RULE7: Only the receive engine sees and updates the receive pointer.
// RULE8: Both pointers clear to zero at reset.

module edp_pointers (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Register port
	input wire logic [edp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [edp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [edp_pkg::DATA_W-1:0] reg_rdata,
	// Controller activity
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic dma_active,
	// Transmit engine
	input wire logic tx_done,
	input wire logic [edp_pkg::DATA_W-1:0] tx_last_desc,
	output logic [edp_pkg::DATA_W-1:0] tx_first_descriptor_address,
	// Receive engine
	input wire logic rx_done,
	input wire logic [edp_pkg::DATA_W-1:0] rx_last_desc,
	output logic [edp_pkg::DATA_W-1:0] rx_first_descriptor_address
);

	////////////////////////////////////////////////////////////////////////
	// Per-channel pointer storage

	logic [edp_pkg::NUM_CH-1:0] sw_we;
	logic [edp_pkg::NUM_CH-1:0] hw_we;
	logic [edp_pkg::PTR_W-1:0] hw_data [edp_pkg::NUM_CH];
	logic [edp_pkg::PTR_W-1:0] ptr_q [edp_pkg::NUM_CH];
	logic [edp_pkg::ADDR_W-1:0] ch_ofs [edp_pkg::NUM_CH];

	assign ch_ofs[edp_pkg::CH_TX] = edp_pkg::OFS_TX_PTR;
	assign ch_ofs[edp_pkg::CH_RX] = edp_pkg::OFS_RX_PTR;
	assign hw_we[edp_pkg::CH_TX] = tx_done; // see RULE6
	assign hw_we[edp_pkg::CH_RX] = rx_done; // see RULE7
	assign hw_data[edp_pkg::CH_TX] =
		tx_last_desc[edp_pkg::DATA_W-1:edp_pkg::PTR_LSB]; // see RULE5
	assign hw_data[edp_pkg::CH_RX] =
		rx_last_desc[edp_pkg::DATA_W-1:edp_pkg::PTR_LSB]; // see RULE5

	genvar gi;
	generate
		for (gi = 0; gi < edp_pkg::NUM_CH; gi++) begin : g_ch
			assign sw_we[gi] = reg_wr && (reg_addr == ch_ofs[gi]);
			edp_ptr_reg u_ptr (
				.mclk(mclk),
				.rst_n(rst_n),
				.sw_we(sw_we[gi]),
				.sw_data(reg_wdata[edp_pkg::DATA_W-1:edp_pkg::PTR_LSB]),
				.hw_we(hw_we[gi]),
				.hw_data(hw_data[gi]),
				.ptr_q(ptr_q[gi])
			); // see RULE1, see RULE2, see RULE3
		end
	endgenerate

	// Low address bits are never stored
	assign tx_first_descriptor_address =
		{ptr_q[edp_pkg::CH_TX], edp_pkg::ALIGN_ZERO}; // see RULE3 see RULE6
	assign rx_first_descriptor_address =
		{ptr_q[edp_pkg::CH_RX], edp_pkg::ALIGN_ZERO}; // see RULE3 see RULE7

	////////////////////////////////////////////////////////////////////////
	// Write-while-busy flag

	logic busy;
	logic wr_busy_q;
	logic wr_busy_d;
	logic st_wr;

	assign busy = tx_active || rx_active || dma_active;
	assign st_wr = reg_wr && (reg_addr == edp_pkg::OFS_STATUS);

	always_comb begin
		wr_busy_d = wr_busy_q;
		if (st_wr && reg_wdata[edp_pkg::ST_WR_BUSY]) begin
			wr_busy_d = 1'b0;
		end
		if ((|sw_we) && busy) begin
			wr_busy_d = 1'b1; // see RULE4
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			wr_busy_q <= 1'b0;
		end else begin
			wr_busy_q <= wr_busy_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read data

	logic [edp_pkg::DATA_W-1:0] rdata_d;
	logic [edp_pkg::DATA_W-1:0] rdata_q;
	logic [edp_pkg::ST_W-1:0] status;

	always_comb begin
		status = '0;
		status[edp_pkg::ST_TX_ACTIVE] = tx_active;
		status[edp_pkg::ST_RX_ACTIVE] = rx_active;
		status[edp_pkg::ST_DMA_ACTIVE] = dma_active;
		status[edp_pkg::ST_WR_BUSY] = wr_busy_q;
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				edp_pkg::OFS_TX_PTR: begin
					rdata_d = tx_first_descriptor_address; // see RULE3
				end
				edp_pkg::OFS_RX_PTR: begin
					rdata_d = rx_first_descriptor_address; // see RULE3
				end
				edp_pkg::OFS_STATUS: begin
					rdata_d = {{(edp_pkg::DATA_W-edp_pkg::ST_W){1'b0}}, status};
				end
				default: begin
					rdata_d = '0;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;

endmodule : edp_pointers

`default_nettype wire

//--- edp_pkg.sv
/*
 * Constants for the descriptor start pointer block: register offsets,
 * field positions and reset values.
 * Assumes a byte-addressed register port with 32-bit words.
 */
`default_nettype none

package edp_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int PTR_LSB = 2;
	localparam int PTR_W = DATA_W - PTR_LSB;
	localparam int NUM_CH = 2;
	localparam int CH_TX = 0;
	localparam int CH_RX = 1;

	localparam logic [ADDR_W-1:0] OFS_TX_PTR = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_RX_PTR = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h08;

	localparam logic [PTR_W-1:0] PTR_RESET = 30'h0000_0000;
	localparam logic [PTR_LSB-1:0] ALIGN_ZERO = 2'h0;

	localparam int ST_TX_ACTIVE = 0;
	localparam int ST_RX_ACTIVE = 1;
	localparam int ST_DMA_ACTIVE = 2;
	localparam int ST_WR_BUSY = 3;
	localparam int ST_W = 4;

endpackage : edp_pkg

`default_nettype wire

//--- edp_ptr_reg.sv
/*
 * One descriptor start pointer: software load and hardware write-back.
 * Assumes write strobes come from logic on mclk.
 */
`timescale 1ns/1ps
`default_nettype none

module edp_ptr_reg (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// Software load
	input wire logic sw_we,
	input wire logic [edp_pkg::PTR_W-1:0] sw_data,
	// Hardware write-back
	input wire logic hw_we,
	input wire logic [edp_pkg::PTR_W-1:0] hw_data,
	// Stored pointer
	output logic [edp_pkg::PTR_W-1:0] ptr_q
);

	logic [edp_pkg::PTR_W-1:0] ptr_d;

	always_comb begin
		ptr_d = ptr_q;
		if (sw_we) begin
			ptr_d = sw_data; // see RULE1
		end
		if (hw_we) begin
			ptr_d = hw_data; // see RULE5
		end
	end

	always_ff @(posedge mclk) begin
		if (!rst_n) begin
			ptr_q <= edp_pkg::PTR_RESET; // see RULE8
		end else begin
			ptr_q <= ptr_d;
		end
	end

endmodule : edp_ptr_reg

`default_nettype wire

//--- edp_props.sv
/* Port checker for edp_pointers.
   Sees only its ports; bound after the module. */
`timescale 1ns/1ps
`default_nettype none
module edp_props (
	input wire logic mclk, rst_n, reg_wr, reg_rd, tx_done, rx_done,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata, reg_rdata, tx_last_desc, rx_last_desc,
	input wire logic [31:0] tx_first_descriptor_address,
	input wire logic [31:0] rx_first_descriptor_address
);
	logic [31:0] t, r;
	logic wt, wr;
	assign t = tx_first_descriptor_address;
	assign r = rx_first_descriptor_address;
	assign wt = reg_wr && reg_addr == 8'h00;
	assign wr = reg_wr && reg_addr == 8'h04;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);
	property p_wt; wt && !tx_done |=> t == ($past(reg_wdata) & ~32'h3);
	endproperty
	a_wt: assert property (p_wt) else $error("tx load");
	property p_wr; wr && !rx_done |=> r == ($past(reg_wdata) & ~32'h3);
	endproperty
	a_wr: assert property (p_wr) else $error("rx load");
	property p_bt; tx_done |=> t == ($past(tx_last_desc) & ~32'h3);
	endproperty
	a_bt: assert property (p_bt) else $error("tx back");
	property p_br; rx_done |=> r == ($past(rx_last_desc) & ~32'h3);
	endproperty
	a_br: assert property (p_br) else $error("rx back");
	property p_ht; !tx_done && !wt |=> $stable(t); endproperty
	a_ht: assert property (p_ht) else $error("tx moved");
	property p_hr; !rx_done && !wr |=> $stable(r); endproperty
	a_hr: assert property (p_hr) else $error("rx moved");
	property p_al; t[1:0] == 2'h0 && r[1:0] == 2'h0; endproperty
	a_al: assert property (p_al) else $error("low bits");
	property p_rd; reg_rd && reg_addr == 8'h00 |=> reg_rdata == $past(t);
	endproperty
	a_rd: assert property (p_rd) else $error("tx read");
endmodule : edp_props
bind edp_pointers edp_props u_props (.*);
`default_nettype wire

//--- edp_dma_model.sv
/* DMA engines beside the pointer block.
   Assumes go pulses from the bench on mclk. */
`timescale 1ns/1ps
`default_nettype none
module edp_dma_model (
	input wire logic mclk, go_tx, go_rx,
	input wire logic [31:0] desc,
	output logic tx_done, rx_done, tx_active, rx_active, dma_active,
	output logic [31:0] tx_last_desc, rx_last_desc
);
	logic [31:0] q;
	always_ff @(posedge mclk) begin
		tx_done <= go_tx;
		rx_done <= go_rx;
		if (go_tx | go_rx) q <= {desc[31:2], 2'h0};
	end
	// Idle lines show the inverse, not a stale value
	assign tx_last_desc = tx_done ? q : ~q;
	assign rx_last_desc = rx_done ? q : ~q;
	assign tx_active = go_tx | tx_done;
	assign rx_active = go_rx | rx_done;
	assign dma_active = tx_active | rx_active;
endmodule : edp_dma_model
`default_nettype wire

//--- tb.sv
/* Testbench for edp_pointers with the DMA model.
   Assumes offsets 0x00, 0x04 and 0x08. */
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, go_tx = 0, go_rx = 0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 0, desc = 0, reg_rdata, tx_last_desc, rx_last_desc;
	logic [31:0] tx_first_descriptor_address, rx_first_descriptor_address;
	logic tx_done, rx_done, tx_active, rx_active, dma_active;
	int bad_count = 0, samples_checked = 0, cyc = 0;
	always #5 mclk = ~mclk;
	edp_dma_model M (.*);
	edp_pointers DUT (.*);
	task automatic chk(input logic [31:0] g, e);
		samples_checked++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected at %0t: %h %h", $time, g, e);
		end
	endtask : chk
	task automatic op(input logic w, r, input logic [7:0] a, input logic [31:0] d);
		reg_wr <= w;
		reg_rd <= r;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		#1;
	endtask : op
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		op(0, 1, a, 0);
		chk(reg_rdata, e);
		op(0, 0, 0, 0);
	endtask : rdc
	task automatic go(input logic t, r, input logic [31:0] d);
		go_tx <= t;
		go_rx <= r;
		desc <= d;
		op(0, 0, 0, 0);
		go_tx <= 0;
		go_rx <= 0;
		op(0, 0, 0, 0);
		op(0, 0, 0, 0);
	endtask : go
	task automatic t_sw;
		rdc(8'h00, 0);
		rdc(8'h04, 0);
		op(1, 0, 8'h00, 32'hdeadbeef);
		chk(tx_first_descriptor_address, 32'hdeadbeec);
		op(1, 0, 8'h04, 32'h12345677);
		chk(rx_first_descriptor_address, 32'h12345674);
		rdc(8'h00, 32'hdeadbeec);
		rdc(8'h0c, 0);
		$display("register test done");
	endtask : t_sw
	task automatic t_wb;
		go(1, 0, 32'ha5a5a5a4);
		chk(tx_first_descriptor_address, 32'ha5a5a5a4);
		chk(rx_first_descriptor_address, 32'h12345674);
		go(0, 1, 32'h00000100);
		chk(rx_first_descriptor_address, 32'h00000100);
		chk(tx_first_descriptor_address, 32'ha5a5a5a4);
		$display("write-back test done");
	endtask : t_wb
	task automatic t_st;
		go_rx <= 1;
		desc <= 32'h00000200;
		op(1, 0, 8'h04, 32'h00000300);
		go_rx <= 0;
		op(0, 0, 0, 0);
		chk(rx_first_descriptor_address, 32'h00000200);
		rdc(8'h08, 32'h00000008);
		op(1, 0, 8'h08, 32'h00000008);
		rdc(8'h08, 0);
		op(1, 0, 8'h00, 32'h00000040);
		rdc(8'h08, 0);
		rdc(8'h00, 32'h00000040);
		$display("status test done");
	endtask : t_st
	task automatic t_rst;
		rst_n <= 0;
		op(0, 0, 0, 0);
		op(0, 0, 0, 0);
		rst_n <= 1;
		rdc(8'h00, 0);
		rdc(8'h04, 0);
		chk(tx_first_descriptor_address, 0);
		chk(rx_first_descriptor_address, 0);
		$display("reset test done");
	endtask : t_rst
	task automatic final_report;
		$display("checks %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : final_report
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 500) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge mclk);
		rst_n <= 1;
		t_sw();
		t_wb();
		t_st();
		t_rst();
		final_report();
	end
endmodule : tb
`default_nettype wire
